// file: hdl/audio_transport_pkg.sv
/*
 * Shared constants and types of the serializer audio transport block:
 * register map, control and status fields, partner codes, the word carrier.
 * Assumes a 32-bit AXI4-Lite register bus and a 10 MHz system clock.
 */
package audio_transport_pkg;

	localparam int DATA_W = 32;
	localparam int LANES = 5;
	localparam int AUX_LANE = 4;
	localparam int PIN_W = 8;
	localparam int ADDR_W = 8;

	// control sits at word index 0x1A, so its byte address is four times that
	localparam logic [ADDR_W-1:0] CTRL_IDX = 8'h1A;
	localparam logic [ADDR_W-1:0] CTRL_OFF = {CTRL_IDX[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h04;

	localparam int CTRL_SURROUND_BIT = 0;
	localparam int CTRL_ISLAND_DIS_BIT = 1;
	localparam int CTRL_FOURCH_BIT = 2;
	localparam int CTRL_TDM_BIT = 3;
	localparam int CTRL_TDM8_BIT = 4;
	localparam int CTRL_AUX_EN_BIT = 5;
	localparam int CTRL_EMB_SRC_BIT = 6;
	localparam logic [6:0] CTRL_RESET = 7'h01;

	localparam int STAT_ISLAND_BIT = 0;
	localparam int STAT_SURROUND_BIT = 1;
	localparam int STAT_18BIT_BIT = 2;
	localparam int STAT_SINGLE_LANE_BIT = 3;
	localparam int STAT_OVERFLOW_BIT = 4;
	localparam int STAT_LANE_MASK_LSB = 8;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [19:0] LEGACY_MIN_KHZ = 20'h061A8;
	localparam logic [19:0] LEGACY_MAX_KHZ = 20'h14C08;

	localparam int TDM_WORD_BCLK = 256;
	localparam logic [7:0] TDM_SLOT_4CH = 8'h40;
	localparam logic [7:0] TDM_SLOT_8CH = 8'h20;

	typedef enum logic [2:0] {
		PARTNER_NEWER = 3'b001,
		PARTNER_LEGACY_2CH = 3'b010,
		PARTNER_LEGACY_GEN = 3'b100
	} partner_e;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [3:0] chan;
		logic aux;
		logic island;
		logic encrypted;
	} audio_word_s;

	localparam int WORD_W = $bits(audio_word_s);

endpackage : audio_transport_pkg

// file: hdl/audio_transport_core.sv
/*
 * Serializer audio transport: samples four I2S lanes (TDM on lane A only) and one auxiliary
 * lane, or takes embedded source audio, picks blanking-island or per-frame
 * transport, encrypts island audio and hands words to the link through a
 * two-entry buffer. Assumes aclk well above the audio bit clock (8x or more),
 * a cipher engine supplying one keystream word per encrypted word, and a
 * link that asserts video_blank during blanking.
 */
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
module audio_transport_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [audio_transport_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [audio_transport_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic audio_bit_clock,
	input wire logic audio_word_select,
	input wire logic audio_lane_a,
	input wire logic audio_lane_b,
	input wire logic audio_lane_c,
	input wire logic audio_lane_d,
	input wire logic gpio0_aux_data,
	input wire logic gpio1_aux_word_select,
	input wire audio_transport_pkg::partner_e partner_type,
	input wire logic [19:0] in_clk_khz,
	input wire logic upstream_surround,
	input wire logic video_blank,
	input wire logic hdcp_active,
	input wire logic [audio_transport_pkg::DATA_W-1:0] cipher_word,
	output logic cipher_step,
	input wire logic emb_valid,
	output logic emb_ready,
	input wire audio_transport_pkg::audio_word_s emb_word,
	output logic out_valid,
	input wire logic out_ready,
	output audio_transport_pkg::audio_word_s out_word,
	output logic single_lane_primary,
	output logic video_18bit,
	output logic surround_active,
	output logic island_active
);
	import audio_transport_pkg::*;

	logic [6:0] ctrl_r;
	logic overflow_r;
	logic [PIN_W-1:0] sync1_r, sync2_r, prev_r;
	logic bit_rise, ws_main, ws_aux;
	logic [7:0] bitcnt_r;
	logic [7:0] slot_w;
	logic [LANES-1:0] lane_en, done, pend_r, take;
	logic [DATA_W-1:0] shift_r [LANES];
	audio_word_s hold_r [LANES];
	audio_word_s push_word;
	logic push_valid, fifo_in_ready, emb_mode, older, tdm_mode;
	audio_word_s fifo_mem [2];
	logic wr_ptr_r, rd_ptr_r;
	logic [1:0] count_r;
	logic aw_take, ar_take;
	logic [31:0] status_w;

	// mode selection
	assign older = (partner_type == PARTNER_LEGACY_2CH) || (partner_type == PARTNER_LEGACY_GEN);
	assign single_lane_primary = older && (in_clk_khz >= LEGACY_MIN_KHZ)
		&& (in_clk_khz <= LEGACY_MAX_KHZ);
	assign video_18bit = (partner_type == PARTNER_LEGACY_2CH) && ctrl_r[CTRL_SURROUND_BIT];
	// an upstream surround request overrides a local island disable
	assign island_active = !ctrl_r[CTRL_ISLAND_DIS_BIT] || upstream_surround;
	assign surround_active = (ctrl_r[CTRL_SURROUND_BIT] || upstream_surround) && island_active
		&& (partner_type != PARTNER_LEGACY_2CH);
	assign emb_mode = ctrl_r[CTRL_EMB_SRC_BIT];
	assign tdm_mode = ctrl_r[CTRL_TDM_BIT];
	assign slot_w = ctrl_r[CTRL_TDM8_BIT] ? TDM_SLOT_8CH : TDM_SLOT_4CH;

	always_comb begin
		lane_en = '0;
		if (!emb_mode) begin
			if (tdm_mode) begin
				lane_en[0] = 1'b1;
			end else if (island_active) begin
				if (surround_active) begin
					lane_en[3:0] = 4'hF;
				end else begin
					lane_en[3:0] = ctrl_r[CTRL_FOURCH_BIT] ? 4'h3 : 4'h1;
				end
			end else begin
				lane_en[3:0] = (partner_type == PARTNER_LEGACY_2CH) ? 4'h3 : 4'h1;
			end
			lane_en[AUX_LANE] = ctrl_r[CTRL_AUX_EN_BIT];
		end
	end

	// pins cross from the audio clock domain; only sync2 is looked at
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
		end else if (clk_en) begin
			sync1_r <= {gpio1_aux_word_select, gpio0_aux_data, audio_lane_d, audio_lane_c,
				audio_lane_b, audio_lane_a, audio_word_select, audio_bit_clock};
			sync2_r <= sync1_r;
			if (sync2_r[0] && !prev_r[0]) begin
				prev_r <= sync2_r;
			end else begin
				prev_r[0] <= sync2_r[0];
			end
		end
	end

	// source launches on the falling edge, so the rising edge sees stable data
	assign bit_rise = sync2_r[0] && !prev_r[0];
	assign ws_main = sync2_r[1];
	assign ws_aux = sync2_r[7];

	// bit position within the TDM frame, restarted at word select rising
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bitcnt_r <= '0;
		end else if (clk_en && bit_rise) begin
			if (ws_main && !prev_r[1]) begin
				bitcnt_r <= 8'h01;
			end else begin
				bitcnt_r <= bitcnt_r + 8'h01; // wraps at TDM_WORD_BCLK
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++) begin : g_lane
			logic ws_now, ws_old, bit_in;
			logic [7:0] pos;
			assign ws_now = (gi == AUX_LANE) ? ws_aux : ws_main;
			assign ws_old = (gi == AUX_LANE) ? prev_r[7] : prev_r[1];
			assign bit_in = sync2_r[gi+2];
			assign pos = (ws_now && !ws_old) ? 8'h00 : bitcnt_r;
			// I2S: the bit on a word select change is still the old word's last
			if (gi == 0) begin : g_tdm
				assign done[gi] = lane_en[gi] && bit_rise && (tdm_mode
					? ((pos & (slot_w - 8'h01)) == (slot_w - 8'h01))
					: (ws_now != ws_old));
			end else begin : g_i2s
				assign done[gi] = lane_en[gi] && bit_rise && (ws_now != ws_old);
			end

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					shift_r[gi] <= '0;
				end else if (clk_en && bit_rise && lane_en[gi]) begin
					shift_r[gi] <= {shift_r[gi][DATA_W-2:0], bit_in};
				end
			end

			// 64-bit TDM slots keep only their last 32 bits
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					hold_r[gi] <= '0;
					pend_r[gi] <= 1'b0;
				end else if (clk_en) begin
					if (done[gi]) begin
						hold_r[gi].data <= {shift_r[gi][DATA_W-2:0], bit_in};
						if (gi == 0 && tdm_mode) begin
							hold_r[gi].chan <= 4'((pos / slot_w));
						end else begin
							hold_r[gi].chan <= 4'((gi % 4) * 2) + {3'h0, ws_old};
						end
						hold_r[gi].aux <= (gi == AUX_LANE);
						hold_r[gi].island <= 1'b0;
						hold_r[gi].encrypted <= 1'b0;
						pend_r[gi] <= 1'b1;
					end else if (take[gi]) begin
						pend_r[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// lowest pending lane goes first; a stalled buffer holds the others
	always_comb begin
		take = '0;
		for (int i = LANES - 1; i >= 0; i--) begin
			if (pend_r[i]) begin
				take = '0;
				take[i] = fifo_in_ready && !emb_mode;
			end
		end
	end

	always_comb begin
		push_word = emb_word;
		push_valid = emb_mode && emb_valid;
		for (int i = LANES - 1; i >= 0; i--) begin
			if (pend_r[i] && !emb_mode) begin
				push_word = hold_r[i];
				push_valid = 1'b1;
			end
		end
		push_word.island = island_active;
		push_word.encrypted = island_active && hdcp_active;
		if (push_word.encrypted) begin
			push_word.data = push_word.data ^ cipher_word;
		end
	end

	assign emb_ready = emb_mode && fifo_in_ready;
	assign cipher_step = push_valid && fifo_in_ready && island_active && hdcp_active;

	// two-entry buffer toward the link
	assign fifo_in_ready = (count_r != 2'h2);
	// island words wait for blanking; frame words go out at once
	// gated by the stored word's own kind, so a mode change cannot leak an island word
	assign out_valid = (count_r != 2'h0) && (!out_word.island || video_blank);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
			fifo_mem[0] <= '0;
			fifo_mem[1] <= '0;
		end else if (clk_en) begin
			if (push_valid && fifo_in_ready) begin
				fifo_mem[wr_ptr_r] <= push_word;
				wr_ptr_r <= !wr_ptr_r;
			end
			if (out_valid && out_ready) begin
				rd_ptr_r <= !rd_ptr_r;
			end
			count_r <= count_r + {1'b0, push_valid && fifo_in_ready}
				- {1'b0, out_valid && out_ready};
		end
	end

	assign out_word = fifo_mem[rd_ptr_r];

	// AXI4-Lite slave: address and data taken together, one of each at a time
	assign aw_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = aw_take;
	assign s_axi_wready = aw_take;
	assign ar_take = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = ar_take;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= CTRL_RESET;
		end else if (clk_en && aw_take && s_axi_awaddr == CTRL_OFF && s_axi_wstrb[0]) begin
			ctrl_r <= s_axi_wdata[6:0];
		end
	end

	// overflow sets when a lane finishes while its last word still waits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overflow_r <= 1'b0;
		end else if (clk_en) begin
			if (|(done & pend_r & ~take)) begin
				overflow_r <= 1'b1;
			end else if (aw_take && s_axi_awaddr == STATUS_OFF && s_axi_wstrb[0]
				&& s_axi_wdata[STAT_OVERFLOW_BIT]) begin
				overflow_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (clk_en) begin
			if (aw_take) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (s_axi_awaddr == CTRL_OFF || s_axi_awaddr == STATUS_OFF)
					? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		status_w = '0;
		status_w[STAT_ISLAND_BIT] = island_active;
		status_w[STAT_SURROUND_BIT] = surround_active;
		status_w[STAT_18BIT_BIT] = video_18bit;
		status_w[STAT_SINGLE_LANE_BIT] = single_lane_primary;
		status_w[STAT_OVERFLOW_BIT] = overflow_r;
		status_w[STAT_LANE_MASK_LSB +: LANES] = lane_en;
	end

	// no path from keystream or key storage reaches the read data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (clk_en) begin
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				if (s_axi_araddr == CTRL_OFF) begin
					s_axi_rdata <= {25'h0, ctrl_r};
				end else if (s_axi_araddr == STATUS_OFF) begin
					s_axi_rdata <= status_w;
				end else begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : audio_transport_core

// file: bench/audio_transport_sva.sv
/*
 * Checker for audio_transport_core: bus answers, word hold, island rules.
 * Bound to every core; assumes clk_en is held high by the bench.
 */
`timescale 1ns/10ps
module audio_transport_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [audio_transport_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire audio_transport_pkg::audio_word_s out_word,
	input wire logic video_blank,
	input wire audio_transport_pkg::partner_e partner_type,
	input wire logic surround_active,
	input wire logic island_active
);
	import audio_transport_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		s_axi_awvalid && s_axi_wvalid && s_axi_awready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (wr_take |=> s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (rd_take |=> s_axi_rvalid)
		else $error("read response late");
	a_read_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_unmapped_read: assert property (rd_take ##0 s_axi_araddr != CTRL_OFF
		&& s_axi_araddr != STATUS_OFF |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read answered");
	a_word_stands: assert property (out_valid && !out_ready
		|=> out_valid && $stable(out_word)) else $error("stalled word changed");
	a_island_blank: assert property (out_valid && out_word.island |-> video_blank)
		else $error("island word outside blanking");
	a_frame_plain: assert property (out_valid && !out_word.island |-> !out_word.encrypted)
		else $error("frame word encrypted");
	a_surround_gate: assert property (surround_active |-> island_active
		&& partner_type != PARTNER_LEGACY_2CH) else $error("surround not allowed");
endmodule : audio_transport_sva

bind audio_transport_core audio_transport_sva chk (.*);

// file: bench/audio_src_model.sv
/*
 * Behavioural I2S source: one left and one right 32-bit word per lane a frame,
 * or one 256-bit TDM word on lane A.
 * Bit clock idles low between frames; aux lane shares clock and word select.
 */
`timescale 1ns/10ps
module audio_src_model (
	output logic audio_bit_clock,
	output logic audio_word_select,
	output wire logic audio_lane_a,
	output wire logic audio_lane_b,
	output wire logic audio_lane_c,
	output wire logic audio_lane_d,
	output wire logic gpio0_aux_data,
	output wire logic gpio1_aux_word_select
);
	logic [4:0] lane;
	assign {gpio0_aux_data, audio_lane_d, audio_lane_c, audio_lane_b, audio_lane_a} = lane;
	assign gpio1_aux_word_select = audio_word_select;
	initial begin
		audio_bit_clock = 1'b0;
		audio_word_select = 1'b0;
		lane = 5'h00;
	end
	// 800 ns period, inside the 1 MHz to 13 MHz window
	task automatic frame(input logic [31:0] base);
		logic [31:0] w [5];
		// keeps pin changes off the core's sampling edges
		#20;
		for (int s = 0; s < 2; s++) begin
			for (int l = 0; l < 4; l++)
				w[l] = base + 32'(2 * l + s);
			w[4] = ~(base + 32'(s));
			for (int i = 31; i >= 0; i--) begin
				audio_bit_clock = 1'b0;
				for (int l = 0; l < 5; l++)
					lane[l] = w[l][i];
				// select flips with the last bit, so that bit closes the word
				if (i == 0)
					audio_word_select = !audio_word_select;
				#400 audio_bit_clock = 1'b1;
				#400;
			end
		end
		audio_bit_clock = 1'b0;
		lane = ~lane;
	endtask : frame
	// select is high for the first bit of slot 0 only
	task automatic tdm(input logic [31:0] base, input int slots);
		int wd;
		logic [31:0] v;
		wd = 256 / slots;
		#20;
		for (int i = 0; i < 256; i++) begin
			audio_bit_clock = 1'b0;
			audio_word_select = (i == 0);
			v = base + 32'(i / wd);
			// wide slots lead with filler; only their last 32 bits count
			lane[0] = (i % wd < wd - 32) ? 1'b1 : v[wd - 1 - i % wd];
			#400 audio_bit_clock = 1'b1;
			#400;
		end
		audio_bit_clock = 1'b0;
	endtask : tdm
endmodule : audio_src_model

// file: bench/tb_top.sv
/*
 * Self-checking bench for audio_transport_core with the I2S source model.
 * Assumes a 100 ns aclk and that keystream stays constant during a run.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top;
	import audio_transport_pkg::*;
	logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, audio_bit_clock, audio_word_select;
	logic audio_lane_a, audio_lane_b, audio_lane_c, audio_lane_d;
	logic gpio0_aux_data, gpio1_aux_word_select, upstream_surround, video_blank;
	logic hdcp_active, cipher_step, emb_valid, emb_ready, out_valid, out_ready;
	logic single_lane_primary, video_18bit, surround_active, island_active;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, cipher_word, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [19:0] in_clk_khz;
	partner_e partner_type;
	audio_word_s emb_word, out_word;
	int fails, tests_run, guard, steps;
	audio_transport_core DUT (.*);
	audio_src_model src (.*);
	// keystream words used, one per encrypted word
	always @(posedge aclk) begin
		if (cipher_step === 1'b1)
			steps++;
	end
	task automatic stop_test();
		if (fails == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	task automatic tick();
		@(posedge aclk);
		guard++;
		if (guard > 3000) begin
			fails++;
			stop_test();
		end
	endtask : tick
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		guard = 0;
		do tick(); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b1;
		do tick(); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		guard = 0;
		do tick(); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do tick(); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	// sampled mid-cycle; the next rising edge consumes the word
	// always waits for a fresh falling edge: at the consuming edge the old word still shows
	task automatic take(input logic [31:0] d, input logic [3:0] c, input logic ax, input logic il);
		guard = 0;
		do begin
			@(negedge aclk);
			guard++;
			if (guard > 3000) begin
				fails++;
				stop_test();
			end
		end while (out_valid !== 1'b1);
		`CHK("data", il ? d ^ cipher_word : d, out_word.data)
		`CHK("chan", c, out_word.chan)
		`CHK("aux", ax, out_word.aux)
		`CHK("island", il, out_word.island)
		`CHK("encrypted", il, out_word.encrypted)
		@(posedge aclk);
	endtask : take
	task automatic expect_frame(input logic [31:0] b, input int n, input logic ax, input logic il);
		fork
			src.frame(b);
			for (int s = 0; s < 2; s++) begin
				for (int l = 0; l < n; l++)
					take(b + 32'(2 * l + s), 4'(2 * l + s), 1'b0, il);
				if (ax)
					take(~(b + 32'(s)), 4'(s), 1'b1, il);
			end
		join
	endtask : expect_frame
	task automatic expect_tdm(input logic [31:0] b, input int n);
		fork
			src.tdm(b, n);
			for (int j = 0; j < n; j++)
				take(b + 32'(j), 4'(j), 1'b0, 1'b1);
		join
	endtask : expect_tdm
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{aresetn, upstream_surround, emb_valid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{clk_en, hdcp_active, video_blank, out_ready} = 4'hF;
		s_axi_wstrb = 4'hF;
		cipher_word = 32'h5A3C_96F0;
		emb_word = '0;
		partner_type = PARTNER_NEWER;
		in_clk_khz = 20'h186A0;
		fails = 0;
		tests_run = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(CTRL_OFF, rd, rs);
		`CHK("ctrl", 32'h0000_0001, rd)
		axi_rd(STATUS_OFF, rd, rs);
		`CHK("status", 32'h0000_0F03, rd)
		axi_rd(8'h08, rd, rs);
		`CHK("unmapped resp", RESP_SLVERR, rs)
		axi_wr(8'h0C, 32'h0000_00FF, rs);
		`CHK("unmapped write", RESP_SLVERR, rs)
		partner_type <= PARTNER_LEGACY_2CH;
		in_clk_khz <= LEGACY_MAX_KHZ;
		@(negedge aclk);
		`CHK("single lane", 1'b1, single_lane_primary)
		`CHK("video 18", 1'b1, video_18bit)
		`CHK("surround", 1'b0, surround_active)
		@(posedge aclk);
		axi_wr(CTRL_OFF, 32'h0000_0000, rs);
		@(negedge aclk);
		`CHK("video 24", 1'b0, video_18bit)
		@(posedge aclk);
		partner_type <= PARTNER_NEWER;
		axi_wr(CTRL_OFF, 32'h0000_0021, rs);
		expect_frame(32'h1000_0000, 4, 1'b1, 1'b1);
		`CHK("keystream", 10, steps)
		axi_wr(CTRL_OFF, 32'h0000_0002, rs);
		partner_type <= PARTNER_LEGACY_2CH;
		expect_frame(32'h2000_0000, 2, 1'b0, 1'b0);
		partner_type <= PARTNER_NEWER;
		expect_frame(32'h3000_0000, 1, 1'b0, 1'b0);
		`CHK("plain frames", 10, steps)
		upstream_surround <= 1'b1;
		@(negedge aclk);
		`CHK("upstream island", 1'b1, island_active)
		`CHK("upstream surround", 1'b1, surround_active)
		@(posedge aclk);
		upstream_surround <= 1'b0;
		partner_type <= PARTNER_LEGACY_2CH;
		out_ready <= 1'b0;
		src.frame(32'h4000_0000);
		src.frame(32'h5000_0000);
		axi_rd(STATUS_OFF, rd, rs);
		`CHK("overflow", 1'b1, rd[STAT_OVERFLOW_BIT])
		axi_wr(STATUS_OFF, 32'h0000_0010, rs);
		out_ready <= 1'b1;
		// a lane that finishes again while pending overwrites its waiting word
		for (int k = 0; k < 4; k++)
			take((k < 2 ? 32'h4000_0000 : 32'h5000_0000) + 32'({k[0], k[1]}),
				4'({k[0], k[1]}), 1'b0, 1'b0);
		axi_rd(STATUS_OFF, rd, rs);
		`CHK("overflow clear", 1'b0, rd[STAT_OVERFLOW_BIT])
		partner_type <= PARTNER_NEWER;
		axi_wr(CTRL_OFF, 32'h0000_0004, rs);
		expect_frame(32'h7000_0000, 2, 1'b0, 1'b1);
		axi_wr(CTRL_OFF, 32'h0000_0040, rs);
		video_blank <= 1'b0;
		emb_word <= {32'h6000_0007, 4'h5, 3'h4};
		emb_valid <= 1'b1;
		guard = 0;
		do tick(); while (emb_ready !== 1'b1);
		emb_valid <= 1'b0;
		@(negedge aclk);
		`CHK("held outside blanking", 1'b0, out_valid)
		@(posedge aclk);
		video_blank <= 1'b1;
		take(32'h6000_0007, 4'h5, 1'b1, 1'b1);
		axi_wr(CTRL_OFF, 32'h0000_0018, rs);
		expect_tdm(32'h8000_0000, 8);
		axi_wr(CTRL_OFF, 32'h0000_0008, rs);
		expect_tdm(32'h9000_0000, 4);
		`CHK("keystream total", 27, steps)
		stop_test();
	end
endmodule : tb_top
